// File: logic/iord_bank.sv
// lower i/o register bank: decode, bit access, flags and port pins
`timescale 1ns/1ns

// Contract
// - reserved bit positions may read as anything; readers ignore them.
// - addresses 0x00 to 0x1F accept single-bit set and clear; higher refuse.
// - bit-accessible registers let the core test one bit and skip.
// - some flags clear on writing one; writing zero leaves them alone.
// - bit set and clear are read-modify-write, so set flags get cleared.
// - io transfers use io addresses 0x00 to 0x3F.
// - data-space address equals io address plus 0x20.
// - extended space 0x60 to 0x1FF is reached only by data-space access.
module iord_bank
  import iord_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // core access
  input wire iord_req_t req,
  output iord_rsp_t rsp,
  // peripheral events and status levels
  input wire iord_evt_t evt,
  input wire iord_stat_t stat,
  // port pins, asynchronous to mclk
  input wire logic [7:0] pin_b,
  input wire logic [7:0] pin_c,
  input wire logic [7:0] pin_d,
  // control towards ports and peripherals
  output iord_ctl_t ctl
);

  // ----------------------------------------------------------------
  // register map decoding
  // ----------------------------------------------------------------

  // an address in none of the three masks below
  // is reserved: it drops writes and reads zero
  // bits that software may write plainly
  function automatic logic [7:0] wr_mask(input logic [5:0] a);
    case (a)
      IORD_PORT_B_DIRECTION, IORD_PORT_B_OUTPUT: wr_mask = IORD_M_FULL;
      IORD_PORT_C_DIRECTION, IORD_PORT_C_OUTPUT: wr_mask = IORD_M_PORT_C;
      IORD_PORT_D_DIRECTION, IORD_PORT_D_OUTPUT: wr_mask = IORD_M_FULL;
      IORD_EXT_INT_MASK, IORD_GENERAL_SCRATCH_0: wr_mask = IORD_M_FULL;
      IORD_EEPROM_CONTROL: wr_mask = IORD_WM_EEPROM_CONTROL;
      IORD_EEPROM_DATA, IORD_EEPROM_ADDRESS_LOW: wr_mask = IORD_M_FULL;
      IORD_EEPROM_ADDRESS_HIGH: wr_mask = IORD_WM_EEPROM_ADDR_HIGH;
      IORD_TIMER_PRESCALER_CONTROL: wr_mask = IORD_WM_PRESCALER;
      IORD_TIMER0_CONTROL_A: wr_mask = IORD_WM_TIMER0_A;
      IORD_TIMER0_CONTROL_B: wr_mask = IORD_WM_TIMER0_B;
      IORD_TIMER0_COUNT, IORD_TIMER0_COMPARE_A: wr_mask = IORD_M_FULL;
      IORD_TIMER0_COMPARE_B: wr_mask = IORD_M_FULL;
      IORD_PLL_CONTROL_STATUS: wr_mask = IORD_WM_PLL;
      IORD_GENERAL_SCRATCH_1, IORD_GENERAL_SCRATCH_2: wr_mask = IORD_M_FULL;
      IORD_SPI_CONTROL, IORD_SPI_DATA: wr_mask = IORD_M_FULL;
      IORD_SPI_STATUS: wr_mask = IORD_WM_SPI_STATUS;
      IORD_COMPARATOR_CONTROL_STATUS: wr_mask = IORD_WM_COMPARATOR;
      IORD_DEBUG_LINK_DATA: wr_mask = IORD_M_FULL;
      IORD_SLEEP_MODE_CONTROL: wr_mask = IORD_WM_SLEEP;
      default: wr_mask = IORD_M_NONE;
    endcase
  endfunction : wr_mask

  // plain and clear masks never overlap, so the
  // clear cannot undo a plain write
  // flag bits cleared by writing a one
  function automatic logic [7:0] w1c_mask(input logic [5:0] a);
    case (a)
      IORD_TIMER0_FLAGS: w1c_mask = IORD_W1C_TIMER0;
      IORD_TIMER1_FLAGS: w1c_mask = IORD_W1C_TIMER1;
      IORD_EXT_INT_FLAGS: w1c_mask = IORD_M_FULL;
      IORD_COMPARATOR_CONTROL_STATUS: w1c_mask = IORD_W1C_COMPARATOR;
      default: w1c_mask = IORD_M_NONE;
    endcase
  endfunction : w1c_mask

  // writes under these bits are dropped, so a live
  // level can never be overridden by software
  // bits whose value comes straight from hardware on read
  function automatic logic [7:0] hw_mask(input logic [5:0] a);
    case (a)
      IORD_PORT_B_INPUT, IORD_PORT_D_INPUT: hw_mask = IORD_M_FULL;
      IORD_PORT_C_INPUT: hw_mask = IORD_M_PORT_C;
      IORD_PLL_CONTROL_STATUS: hw_mask = IORD_HW_PLL;
      IORD_SPI_STATUS: hw_mask = IORD_HW_SPI_STATUS;
      IORD_COMPARATOR_CONTROL_STATUS: hw_mask = IORD_HW_COMPARATOR;
      default: hw_mask = IORD_M_NONE;
    endcase
  endfunction : hw_mask

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // one struct, so reset and enable reach every
  // bit of the bank in the same way
  iord_state_t st_r;
  iord_state_t st_nxt;

  // reads see the state as it stood at the taking edge
  // hardware-fed bits for every address, assembled once per cycle
  logic [63:0][7:0] hw_val;

  // reserved bits could read as anything; zero
  // keeps the view repeatable
  // read view of one io address, reserved bits forced low
  function automatic logic [7:0] read_view(input logic [5:0] a,
                                           input logic [63:0][7:0] regs,
                                           input logic [63:0][7:0] hw);
    logic [7:0] live;
    logic [7:0] keep;
    live = hw_mask(a);
    keep = wr_mask(a) | w1c_mask(a);
    read_view = (regs[a] & keep) | (hw[a] & live);
  endfunction : read_view

  // ----------------------------------------------------------------
  // hardware-fed read values
  // ----------------------------------------------------------------

  // status levels already come from flip-flops on
  // this clock; another stage would add latency
  // pin values sit in the input slots once debounced; status levels are live
  always_comb
  begin
    // unused slots stay zero
    hw_val = '0;
    hw_val[IORD_PORT_B_INPUT] = st_r.regs[IORD_PORT_B_INPUT];
    hw_val[IORD_PORT_C_INPUT] = st_r.regs[IORD_PORT_C_INPUT];
    hw_val[IORD_PORT_D_INPUT] = st_r.regs[IORD_PORT_D_INPUT];
    // live levels land on their own bits only
    hw_val[IORD_PLL_CONTROL_STATUS][0] = stat.pll_lock;
    hw_val[IORD_SPI_STATUS][7:6] = stat.spi_flags;
    hw_val[IORD_COMPARATOR_CONTROL_STATUS][IORD_ACO_BIT] = stat.comparator_out;
  end

  // ----------------------------------------------------------------
  // access decode and next state
  // ----------------------------------------------------------------
  // decode scratch, all set at the top of the process
  logic [5:0] io_a;
  logic is_io_op;
  logic is_bit_op;
  logic is_write;
  logic in_io_range;
  logic refuse;
  logic [7:0] rv;
  logic [7:0] one_hot;
  logic [7:0] wd;
  logic [7:0] wm;
  logic [7:0] cm;
  logic [8:0] data_off;

  always_comb
  begin
    // hold by default; each section overrides its own part
    st_nxt = st_r;
    io_a = req.addr[5:0];
    // data-space form, meaningful in the window only
    data_off = req.addr - IORD_DATA_IO_OFFSET;
    is_io_op = 1'b0;
    is_bit_op = 1'b0;
    is_write = 1'b0;
    in_io_range = 1'b0;
    refuse = 1'b0;
    rv = '0;
    // one bit set at the selected position
    one_hot = 8'h01 << req.bitsel;
    wd = '0;
    wm = '0;
    cm = '0;

    // data loads fall to the default: no write and
    // no io form of the address
    // classify the operation
    case (req.op)
      IORD_OP_IO_RD: is_io_op = 1'b1;
      IORD_OP_IO_WR:
      begin
        is_io_op = 1'b1;
        is_write = 1'b1;
      end
      IORD_OP_BIT_SET_INSTR, IORD_OP_BIT_CLEAR_INSTR:
      begin
        is_io_op = 1'b1;
        is_bit_op = 1'b1;
        is_write = 1'b1;
      end
      IORD_OP_SKIP_IF_BIT_SET_INSTR, IORD_OP_SKIP_IF_BIT_CLEAR_INSTR:
      begin
        is_io_op = 1'b1;
        is_bit_op = 1'b1;
      end
      IORD_OP_DATA_STORE_INSTR: is_write = 1'b1;
      default: is_write = 1'b0;
    endcase

    // an io op can still carry an address above 0x3F; refusing
    // it stops aliasing onto a low register
    // map the request to one io address, or send it elsewhere
    if (is_io_op)
    begin
      // io instructions carry six address bits; anything above is refused
      in_io_range = (req.addr[8:6] == 3'h0);
      refuse = !in_io_range;
    end
    else
    begin
      // data space: io window sits 0x20 up, extended space is not ours
      in_io_range = (req.addr >= IORD_DATA_IO_OFFSET) && (req.addr < IORD_EXT_FIRST);
      // the low six bits name the register
      io_a = data_off[5:0];
    end

    // limitation: skip tests share this limit, so a
    // test in 0x20..0x3F is refused, not answered
    // single-bit forms only reach the low half of the space
    if (is_bit_op && in_io_range && (io_a > IORD_BIT_ACC_LAST))
    begin
      refuse = 1'b1;
      in_io_range = 1'b0;
    end

    // the view drops reserved bits, so a bit form
    // never writes back junk from them
    rv = read_view(io_a, st_r.regs, hw_val);

    // write data: bit forms rewrite the whole register as read
    case (req.op)
      IORD_OP_BIT_SET_INSTR: wd = rv | one_hot;
      IORD_OP_BIT_CLEAR_INSTR: wd = rv & ~one_hot;
      default: wd = req.wdata;
    endcase

    // one cycle of latency buys outputs that all
    // come straight from flip-flops
    // response is registered one cycle after the request
    st_nxt.rsp = '0;
    // both pulses drop unless a request is taken
    st_nxt.wr_pulse = 1'b0;
    if (req.valid)
    begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.refused = refuse;
      st_nxt.rsp.elsewhere = !refuse && !in_io_range;
      // writes, refusals and foreign addresses read zero
      st_nxt.rsp.rdata = (in_io_range && !is_write) ? rv : IORD_REG_RESET;
      // the tested bit comes from the read view
      if (in_io_range && req.op == IORD_OP_SKIP_IF_BIT_SET_INSTR)
        st_nxt.rsp.skip = rv[req.bitsel];
      if (in_io_range && req.op == IORD_OP_SKIP_IF_BIT_CLEAR_INSTR)
        st_nxt.rsp.skip = !rv[req.bitsel];
    end

    // the strobe fires for reserved addresses too, so
    // a watcher sees every store that lands in the io range
    // one register is written per access; reserved addresses have empty masks
    if (req.valid && is_write && in_io_range)
    begin
      wm = wr_mask(io_a);
      cm = w1c_mask(io_a);
      st_nxt.regs[io_a] = (st_r.regs[io_a] & ~wm) | (wd & wm);
      // a one clears the flag, a zero leaves it
      st_nxt.regs[io_a] = st_nxt.regs[io_a] & ~(wd & cm);
      st_nxt.wr_pulse = 1'b1;
      // the strobe carries the write data limited to the plainly writable bits
      st_nxt.wr_addr = io_a;
      st_nxt.wr_data = wd & wm;
    end

    // event and clear in one cycle leave the flag set:
    // software never loses an unseen event
    // events set flags after the clear so a coincident event survives
    st_nxt.regs[IORD_TIMER0_FLAGS][2:0] = st_nxt.regs[IORD_TIMER0_FLAGS][2:0] | evt.timer0;
    // timer 1 has no flag on bit 4
    st_nxt.regs[IORD_TIMER1_FLAGS][3:0] =
      st_nxt.regs[IORD_TIMER1_FLAGS][3:0] | evt.timer1[3:0];
    st_nxt.regs[IORD_TIMER1_FLAGS][IORD_ICF1_BIT] =
      st_nxt.regs[IORD_TIMER1_FLAGS][IORD_ICF1_BIT] | evt.timer1[4];
    st_nxt.regs[IORD_EXT_INT_FLAGS] = st_nxt.regs[IORD_EXT_INT_FLAGS] | evt.ext_int;
    st_nxt.regs[IORD_COMPARATOR_CONTROL_STATUS][IORD_ACI_BIT] =
      st_nxt.regs[IORD_COMPARATOR_CONTROL_STATUS][IORD_ACI_BIT] | evt.comparator;

    // a bit still moving keeps its old value, so a
    // read never sees a half-settled level
    // pin synchroniser: third stage compared with second, first read only by second
    // stage one may be metastable; only stage two reads it
    st_nxt.sync1 = {pin_d, pin_c, pin_b};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    // pin b in bits 7:0, c in 15:8, d in 23:16
    for (int i = 0; i < 8; i++)
    begin
      if (st_r.sync2[i] == st_r.sync3[i])
        st_nxt.regs[IORD_PORT_B_INPUT][i] = st_r.sync3[i];
      if (st_r.sync2[8 + i] == st_r.sync3[8 + i])
        st_nxt.regs[IORD_PORT_C_INPUT][i] = st_r.sync3[8 + i];
      if (st_r.sync2[16 + i] == st_r.sync3[16 + i])
        st_nxt.regs[IORD_PORT_D_INPUT][i] = st_r.sync3[16 + i];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // reset wins even with the enable low, so a
  // stalled block still leaves reset cleanly
  // enable low freezes everything, including the pin pipeline
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      // no reset values are defined: all start at zero
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all taken from flip-flops
  // ----------------------------------------------------------------
  // port c bit 3 has no pin and is forced low here too
  assign rsp = st_r.rsp;
  assign ctl.port_b_dir = st_r.regs[IORD_PORT_B_DIRECTION];
  assign ctl.port_b_out = st_r.regs[IORD_PORT_B_OUTPUT];
  assign ctl.port_c_dir = st_r.regs[IORD_PORT_C_DIRECTION] & IORD_M_PORT_C;
  assign ctl.port_c_out = st_r.regs[IORD_PORT_C_OUTPUT] & IORD_M_PORT_C;
  assign ctl.port_d_dir = st_r.regs[IORD_PORT_D_DIRECTION];
  assign ctl.port_d_out = st_r.regs[IORD_PORT_D_OUTPUT];
  // strobe stands for one cycle; address and data hold until the next write
  assign ctl.wr_pulse = st_r.wr_pulse; // lets peripherals take data registers
  assign ctl.wr_addr = st_r.wr_addr;
  assign ctl.wr_data = st_r.wr_data;

endmodule : iord_bank

// File: logic/iord_pkg.sv
// shared constants, types and carriers of the lower i/o register bank
package iord_pkg;

  // ----------------------------------------------------------------
  // address space
  // ----------------------------------------------------------------
  localparam logic [5:0] IORD_BIT_ACC_LAST = 6'h1F;
  localparam logic [8:0] IORD_DATA_IO_OFFSET = 9'h020;
  localparam logic [8:0] IORD_EXT_FIRST = 9'h060;
  localparam logic [7:0] IORD_REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // register i/o addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] IORD_PORT_B_INPUT = 6'h03;
  localparam logic [5:0] IORD_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] IORD_PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] IORD_PORT_C_INPUT = 6'h06;
  localparam logic [5:0] IORD_PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] IORD_PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] IORD_PORT_D_INPUT = 6'h09;
  localparam logic [5:0] IORD_PORT_D_DIRECTION = 6'h0A;
  localparam logic [5:0] IORD_PORT_D_OUTPUT = 6'h0B;
  localparam logic [5:0] IORD_TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] IORD_TIMER1_FLAGS = 6'h16;
  localparam logic [5:0] IORD_EXT_INT_FLAGS = 6'h1C;
  localparam logic [5:0] IORD_EXT_INT_MASK = 6'h1D;
  localparam logic [5:0] IORD_GENERAL_SCRATCH_0 = 6'h1E;
  localparam logic [5:0] IORD_EEPROM_CONTROL = 6'h1F;
  localparam logic [5:0] IORD_EEPROM_DATA = 6'h20;
  localparam logic [5:0] IORD_EEPROM_ADDRESS_LOW = 6'h21;
  localparam logic [5:0] IORD_EEPROM_ADDRESS_HIGH = 6'h22;
  localparam logic [5:0] IORD_TIMER_PRESCALER_CONTROL = 6'h23;
  localparam logic [5:0] IORD_TIMER0_CONTROL_A = 6'h24;
  localparam logic [5:0] IORD_TIMER0_CONTROL_B = 6'h25;
  localparam logic [5:0] IORD_TIMER0_COUNT = 6'h26;
  localparam logic [5:0] IORD_TIMER0_COMPARE_A = 6'h27;
  localparam logic [5:0] IORD_TIMER0_COMPARE_B = 6'h28;
  localparam logic [5:0] IORD_PLL_CONTROL_STATUS = 6'h29;
  localparam logic [5:0] IORD_GENERAL_SCRATCH_1 = 6'h2A;
  localparam logic [5:0] IORD_GENERAL_SCRATCH_2 = 6'h2B;
  localparam logic [5:0] IORD_SPI_CONTROL = 6'h2C;
  localparam logic [5:0] IORD_SPI_STATUS = 6'h2D;
  localparam logic [5:0] IORD_SPI_DATA = 6'h2E;
  localparam logic [5:0] IORD_COMPARATOR_CONTROL_STATUS = 6'h30;
  localparam logic [5:0] IORD_DEBUG_LINK_DATA = 6'h31;
  localparam logic [5:0] IORD_SLEEP_MODE_CONTROL = 6'h33;

  // ----------------------------------------------------------------
  // field masks: software-writable, write-one-to-clear, hardware-fed
  // ----------------------------------------------------------------
  localparam logic [7:0] IORD_M_FULL = 8'hFF;
  localparam logic [7:0] IORD_M_NONE = 8'h00;
  localparam logic [7:0] IORD_M_PORT_C = 8'hF7;
  localparam logic [7:0] IORD_W1C_TIMER0 = 8'h07;
  localparam logic [7:0] IORD_W1C_TIMER1 = 8'h2F;
  localparam logic [7:0] IORD_WM_EEPROM_CONTROL = 8'h3F;
  localparam logic [7:0] IORD_WM_EEPROM_ADDR_HIGH = 8'h03;
  localparam logic [7:0] IORD_WM_PRESCALER = 8'h83;
  localparam logic [7:0] IORD_WM_TIMER0_A = 8'hF3;
  localparam logic [7:0] IORD_WM_TIMER0_B = 8'hCF;
  localparam logic [7:0] IORD_WM_PLL = 8'h1E;
  localparam logic [7:0] IORD_HW_PLL = 8'h01;
  localparam logic [7:0] IORD_WM_SPI_STATUS = 8'h01;
  localparam logic [7:0] IORD_HW_SPI_STATUS = 8'hC0;
  localparam logic [7:0] IORD_WM_COMPARATOR = 8'hCF;
  localparam logic [7:0] IORD_W1C_COMPARATOR = 8'h10;
  localparam logic [7:0] IORD_HW_COMPARATOR = 8'h20;
  localparam logic [7:0] IORD_WM_SLEEP = 8'h0F;
  localparam int IORD_ACI_BIT = 4;
  localparam int IORD_ACO_BIT = 5;
  localparam int IORD_ICF1_BIT = 5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IORD_OP_IO_RD, IORD_OP_IO_WR, IORD_OP_BIT_SET_INSTR, IORD_OP_BIT_CLEAR_INSTR,
    IORD_OP_SKIP_IF_BIT_SET_INSTR, IORD_OP_SKIP_IF_BIT_CLEAR_INSTR,
    IORD_OP_DATA_LOAD_INSTR, IORD_OP_DATA_STORE_INSTR
  } iord_op_t;

  typedef struct packed {
    logic valid;
    iord_op_t op;
    logic [8:0] addr;
    logic [2:0] bitsel;
    logic [7:0] wdata;
  } iord_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic skip;
    logic refused;
    logic elsewhere;
  } iord_rsp_t;

  typedef struct packed {
    logic [2:0] timer0;
    logic [4:0] timer1;
    logic [7:0] ext_int;
    logic comparator;
  } iord_evt_t;

  typedef struct packed {
    logic [1:0] spi_flags;
    logic comparator_out;
    logic pll_lock;
  } iord_stat_t;

  typedef struct packed {
    logic [7:0] port_b_dir;
    logic [7:0] port_b_out;
    logic [7:0] port_c_dir;
    logic [7:0] port_c_out;
    logic [7:0] port_d_dir;
    logic [7:0] port_d_out;
    logic wr_pulse;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
  } iord_ctl_t;

  typedef struct packed {
    logic [63:0][7:0] regs;
    logic [23:0] sync1;
    logic [23:0] sync2;
    logic [23:0] sync3;
    iord_rsp_t rsp;
    logic wr_pulse;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
  } iord_state_t;

endpackage : iord_pkg

// File: bench/iord_bank_assertions.sv
// port checker of the lower i/o register bank
`timescale 1ns/1ns
module iord_bank_checker
  import iord_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // core access
  input wire iord_req_t req,
  input wire iord_rsp_t rsp,
  // peripheral side
  input wire iord_evt_t evt,
  input wire iord_stat_t stat,
  input wire logic [7:0] pin_b,
  input wire logic [7:0] pin_c,
  input wire logic [7:0] pin_d,
  input wire iord_ctl_t ctl
);
  // ----
  // request classes
  // ----
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic tk;
  logic io_op;
  logic dat_op;
  logic bit_op;
  logic wr_bit;
  assign tk = ce && req.valid;
  assign io_op = req.op inside {IORD_OP_IO_RD, IORD_OP_IO_WR};
  assign dat_op = req.op inside {IORD_OP_DATA_LOAD_INSTR, IORD_OP_DATA_STORE_INSTR};
  assign bit_op = !io_op && !dat_op;
  assign wr_bit = req.op inside {IORD_OP_BIT_SET_INSTR, IORD_OP_BIT_CLEAR_INSTR};
  // ----
  // decode and response
  // ----
  rsp_follows_a: assert property (tk |=> rsp.valid)
    else $error("no response after a taken request");
  rsp_idle_a: assert property (ce && !req.valid |=> !rsp.valid)
    else $error("response without a request");
  io_refused_a: assert property (tk && io_op && req.addr > 9'h03F |=> rsp.refused && !ctl.wr_pulse)
    else $error("io access above the io range taken");
  bit_refused_a: assert property (tk && bit_op && req.addr > 9'h01F |=> rsp.refused && !ctl.wr_pulse)
    else $error("bit access above the bit range taken");
  bit_write_a: assert property (tk && wr_bit && req.addr <= 9'h01F |=>
    !rsp.refused && ctl.wr_pulse && {3'h0, ctl.wr_addr} == $past(req.addr))
    else $error("bit set or clear did not write its register back");
  data_elsewhere_a: assert property (tk && dat_op && (req.addr < 9'h020 || req.addr >= 9'h060) |=>
    rsp.elsewhere && !ctl.wr_pulse)
    else $error("data access outside the io window hit the bank");
  store_offset_a: assert property (tk && req.op == IORD_OP_DATA_STORE_INSTR &&
    req.addr inside {[9'h020:9'h05F]} |=> ctl.wr_pulse && ctl.wr_addr == 6'($past(req.addr) - 9'h020))
    else $error("data store landed on the wrong io address");
  io_write_a: assert property (tk && req.op == IORD_OP_IO_WR && req.addr <= 9'h03F |=>
    ctl.wr_pulse && {3'h0, ctl.wr_addr} == $past(req.addr))
    else $error("io write landed on the wrong io address");
  skip_set_a: assert property (tk && req.op == IORD_OP_SKIP_IF_BIT_SET_INSTR &&
    req.addr <= 9'h01F |=> rsp.skip == rsp.rdata[$past(req.bitsel)])
    else $error("skip on set disagrees with the tested bit");
  skip_clear_a: assert property (tk && req.op == IORD_OP_SKIP_IF_BIT_CLEAR_INSTR &&
    req.addr <= 9'h01F |=> rsp.skip != rsp.rdata[$past(req.bitsel)])
    else $error("skip on clear disagrees with the tested bit");
  port_c_gap_a: assert property (!ctl.port_c_out[3] && !ctl.port_c_dir[3])
    else $error("missing port c bit driven");
endmodule : iord_bank_checker

bind iord_bank iord_bank_checker i_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce), .req(req),
  .rsp(rsp), .evt(evt), .stat(stat), .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d), .ctl(ctl));

// File: bench/iord_core_model.sv
// processor core model issuing io and data-space accesses
`timescale 1ns/1ns
module iord_core_model
  import iord_pkg::*;
(
  // clock
  input wire logic mclk,
  // access port
  output iord_req_t req,
  input wire iord_rsp_t rsp
);
  // idle at time zero
  initial req = '0;
  // one access: launch after an edge, answer is sampled just after the taking edge
  task automatic xfer(input iord_op_t op, input logic [8:0] a, input logic [2:0] b,
    input logic [7:0] wd, output iord_rsp_t r);
    @(posedge mclk);
    // callers hand in mapped addresses with reserved bits zeroed
    req <= '{valid: 1'b1, op: op, addr: a, bitsel: b, wdata: wd};
    @(posedge mclk);
    // released address, bit and data lines carry inverted junk so a stale value never passes as live
    req <= '{valid: 1'b0, op: op, addr: ~a, bitsel: ~b, wdata: ~wd};
    #1;
    r = rsp;
  endtask : xfer
endmodule : iord_core_model

// File: bench/tb_iord_bank.sv
// self-checking bench of the lower i/o register bank
`timescale 1ns/1ns
module tb_iord_bank;
  import iord_pkg::*;
  // ----
  // clock, design and counters
  // ----
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  iord_req_t req;
  iord_rsp_t rsp;
  iord_rsp_t r;
  iord_evt_t evt = '0;
  iord_stat_t stat = '0;
  logic [7:0] pin_b = 8'h00;
  logic [7:0] pin_c = 8'h00;
  logic [7:0] pin_d = 8'h00;
  iord_ctl_t ctl;
  int err_count = 0;
  int samples_checked = 0;
  logic [5:0] ta [6] = '{6'h04, 6'h08, 6'h1E, 6'h22, 6'h26, 6'h33};
  logic [7:0] tm [6] = '{8'hFF, 8'hF7, 8'hFF, 8'h03, 8'hFF, 8'h0F};
  iord_op_t eo [5] = '{IORD_OP_DATA_LOAD_INSTR, IORD_OP_DATA_STORE_INSTR,
    IORD_OP_DATA_LOAD_INSTR, IORD_OP_IO_RD, IORD_OP_IO_WR};
  logic [8:0] ea [5] = '{9'h01F, 9'h060, 9'h1FF, 9'h060, 9'h040};
  logic [7:0] ee [5] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h02};
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  // enable is dropped once to check that state freezes
  iord_bank i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .req(req), .rsp(rsp), .evt(evt),
    .stat(stat), .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d), .ctl(ctl));
  iord_core_model i_core (.mclk(mclk), .req(req), .rsp(rsp));
  // ----
  // helpers
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input iord_op_t op, input logic [8:0] a, input logic [2:0] b,
    input logic [7:0] wd);
    i_core.xfer(op, a, b, wd, r);
  endtask : acc
  task automatic rd(input logic [5:0] a);
    acc(IORD_OP_IO_RD, {3'h0, a}, 3'h0, 8'h00);
  endtask : rd
  function automatic logic [7:0] pat(input int i);
    return 8'h91 + 8'(i * 23);
  endfunction : pat
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  // hang guard
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_count++;
    test_done();
  end
  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    // store through the data window, read back both ways to catch aliasing
    for (int i = 0; i < 6; i++)
    begin
      acc(IORD_OP_DATA_STORE_INSTR, {3'h0, ta[i]} + IORD_DATA_IO_OFFSET, 3'h0, pat(i) & tm[i]);
      check({ctl.wr_pulse, 1'b0, ctl.wr_addr}, {2'h2, ta[i]});
      check(ctl.wr_data, pat(i) & tm[i]);
    end
    for (int i = 0; i < 6; i++)
    begin
      rd(ta[i]);
      check(r.rdata & tm[i], pat(i) & tm[i]);
      acc(IORD_OP_DATA_LOAD_INSTR, {3'h0, ta[i]} + IORD_DATA_IO_OFFSET, 3'h0, 8'h00);
      check(r.rdata & tm[i], pat(i) & tm[i]);
    end
    check(ctl.port_b_dir, pat(0));
    check(ctl.port_c_out, pat(1) & 8'hF7);
    acc(IORD_OP_IO_WR, 9'h00A, 3'h0, 8'h5A);
    check(ctl.port_d_dir, 8'h5A);
    acc(IORD_OP_IO_WR, 9'h00B, 3'h0, 8'hC3);
    check(ctl.port_d_out, 8'hC3);
    acc(IORD_OP_IO_WR, 9'h007, 3'h0, 8'hF7);
    check(ctl.port_c_dir, 8'hF7);
    // accesses outside the reach of their instruction kind
    for (int i = 0; i < 5; i++)
    begin
      acc(eo[i], ea[i], 3'h0, 8'h00);
      check({6'h00, r.refused, r.elsewhere}, ee[i]);
    end
    // bit set and clear, and a refused one above the bit range
    acc(IORD_OP_IO_WR, 9'h005, 3'h0, 8'h00);
    acc(IORD_OP_BIT_SET_INSTR, 9'h005, 3'h3, 8'h00);
    acc(IORD_OP_BIT_SET_INSTR, 9'h005, 3'h7, 8'h00);
    acc(IORD_OP_BIT_CLEAR_INSTR, 9'h005, 3'h3, 8'h00);
    rd(IORD_PORT_B_OUTPUT);
    check(r.rdata, 8'h80);
    check(ctl.port_b_out, 8'h80);
    acc(IORD_OP_BIT_SET_INSTR, 9'h026, 3'h4, 8'h00);
    check({7'h00, r.refused}, 8'h01);
    rd(IORD_TIMER0_COUNT);
    check(r.rdata, pat(4));
    // bit tests with skip
    acc(IORD_OP_SKIP_IF_BIT_SET_INSTR, 9'h005, 3'h7, 8'h00);
    check({7'h00, r.skip}, 8'h01);
    acc(IORD_OP_SKIP_IF_BIT_SET_INSTR, 9'h005, 3'h3, 8'h00);
    check({7'h00, r.skip}, 8'h00);
    acc(IORD_OP_SKIP_IF_BIT_CLEAR_INSTR, 9'h005, 3'h3, 8'h00);
    check({7'h00, r.skip}, 8'h01);
    acc(IORD_OP_SKIP_IF_BIT_CLEAR_INSTR, 9'h02E, 3'h0, 8'h00);
    check({7'h00, r.refused}, 8'h01);
    // flags raised by events, cleared by writing one
    @(posedge mclk);
    evt <= '{timer0: 3'h7, timer1: 5'h10, ext_int: 8'hFF, comparator: 1'b1};
    @(posedge mclk);
    evt <= '0;
    rd(IORD_TIMER1_FLAGS);
    check(r.rdata, 8'h20);
    acc(IORD_OP_IO_WR, 9'h015, 3'h0, 8'h02);
    rd(IORD_TIMER0_FLAGS);
    check(r.rdata, 8'h05);
    acc(IORD_OP_IO_WR, 9'h015, 3'h0, 8'h00);
    rd(IORD_TIMER0_FLAGS);
    check(r.rdata, 8'h05);
    // read-modify-write clears every flag read as set, except the bit written zero
    acc(IORD_OP_BIT_SET_INSTR, 9'h015, 3'h1, 8'h00);
    rd(IORD_TIMER0_FLAGS);
    check(r.rdata, 8'h00);
    acc(IORD_OP_BIT_CLEAR_INSTR, 9'h01C, 3'h0, 8'h00);
    rd(IORD_EXT_INT_FLAGS);
    check(r.rdata, 8'h01);
    // enable low freezes state: an event seen meanwhile sets nothing
    @(posedge mclk);
    ce <= 1'b0;
    evt <= '{timer0: 3'h2, timer1: 5'h00, ext_int: 8'h00, comparator: 1'b0};
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    evt <= '0;
    rd(IORD_TIMER0_FLAGS);
    check(r.rdata, 8'h00);
    // pins through the synchroniser and live status levels
    @(posedge mclk);
    pin_b <= 8'h3C;
    pin_c <= 8'hFF;
    pin_d <= 8'hA5;
    stat <= '{spi_flags: 2'b10, comparator_out: 1'b1, pll_lock: 1'b1};
    repeat (6) @(posedge mclk);
    rd(IORD_PORT_D_INPUT);
    check(r.rdata, 8'hA5);
    rd(IORD_PORT_B_INPUT);
    check(r.rdata, 8'h3C);
    rd(IORD_PORT_C_INPUT);
    check(r.rdata & 8'hF7, 8'hF7);
    rd(IORD_PLL_CONTROL_STATUS);
    check(r.rdata & 8'h01, 8'h01);
    rd(IORD_SPI_STATUS);
    check(r.rdata & 8'hC0, 8'h80);
    rd(IORD_COMPARATOR_CONTROL_STATUS);
    check(r.rdata & 8'h30, 8'h30);
    test_done();
  end
endmodule : tb_iord_bank
